// file: aesl_pkg.sv
// aesl_pkg: constants and carrier types for the amplifier event status latches
// assumes: one 8-bit register per address on the device's internal register port
package aesl_pkg;

   // ***********************************************************
   // register addresses
   // ***********************************************************
   localparam logic [15:0] AESL_RAW_THERMAL_ADDR   = 16'h2001;
   localparam logic [15:0] AESL_RAW_CLOCK_ADDR     = 16'h2002;
   localparam logic [15:0] AESL_RAW_SUPPLY_ADDR    = 16'h2003;
   localparam logic [15:0] AESL_RAW_BROWNOUT_ADDR  = 16'h2004;
   localparam logic [15:0] AESL_STKY_THERMAL_ADDR  = 16'h2006;
   localparam logic [15:0] AESL_STKY_CLOCK_ADDR    = 16'h2007;
   localparam logic [15:0] AESL_STKY_SUPPLY_ADDR   = 16'h2008;
   localparam logic [15:0] AESL_STKY_BROWNOUT_ADDR = 16'h2009;

   // ***********************************************************
   // groups, field positions, reset values
   // ***********************************************************
   localparam int          AESL_GROUPS          = 4;
   localparam int          AESL_GRP_THERMAL     = 0;
   localparam int          AESL_GRP_CLOCK       = 1;
   localparam int          AESL_GRP_SUPPLY      = 2;
   localparam int          AESL_GRP_BROWNOUT    = 3;
   localparam logic [7:0]  AESL_RESET_VALUE     = 8'h00;
   localparam logic [7:0]  AESL_UNMAPPED_VALUE  = 8'h00;
   // implemented bits per group: clock group bit 3 and brownout bits 7..4 unused
   localparam logic [AESL_GROUPS-1:0][7:0] AESL_VALID_MASK = {8'h0F, 8'hFF, 8'hF7, 8'hFF};

   // supply group field positions
   localparam int AESL_BIT_ANALOG_SUPPLY_UNDERVOLT  = 7;
   localparam int AESL_BIT_CORE_SUPPLY_UNDERVOLT    = 6;
   localparam int AESL_BIT_POWERUP_COMPLETE         = 5;
   localparam int AESL_BIT_POWERDOWN_COMPLETE       = 4;
   localparam int AESL_BIT_SPEAKER_SUPPLY_UNDERVOLT = 3;
   localparam int AESL_BIT_BATTERY_UNDERVOLT        = 2;
   localparam int AESL_BIT_HEADROOM_TRACK_BEGIN     = 1;
   localparam int AESL_BIT_HEADROOM_TRACK_END       = 0;
   // brownout group field positions
   localparam int AESL_BIT_BROWNOUT_LEVEL_ZERO      = 3;
   localparam int AESL_BIT_BROWNOUT_LEVEL_CHANGE    = 2;
   localparam int AESL_BIT_BROWNOUT_BEGIN           = 1;
   localparam int AESL_BIT_BROWNOUT_END             = 0;
   // thermal group field positions
   localparam int AESL_BIT_OVERTEMP_SHUTDOWN_BEGIN  = 7;
   localparam int AESL_BIT_OVERTEMP_SHUTDOWN_END    = 6;
   localparam int AESL_BIT_TEMP_WARNING_ONE_BEGIN   = 5;
   localparam int AESL_BIT_TEMP_WARNING_ONE_END     = 4;
   localparam int AESL_BIT_THERMAL_FOLDBACK_BEGIN   = 3;
   localparam int AESL_BIT_THERMAL_FOLDBACK_END     = 2;
   localparam int AESL_BIT_FUSE_LOAD_FAILURE        = 1;
   localparam int AESL_BIT_SPEAKER_OVERCURRENT      = 0;
   // clock/data group field positions
   localparam int AESL_BIT_TEMP_WARNING_TWO_BEGIN   = 7;
   localparam int AESL_BIT_TEMP_WARNING_TWO_END     = 6;
   localparam int AESL_BIT_INTERNAL_SPEAKER_MON_ERR = 5;
   localparam int AESL_BIT_INTERNAL_CLOCK_ERR       = 4;
   localparam int AESL_BIT_CLOCK_RECOVERY           = 2;
   localparam int AESL_BIT_CLOCK_ERR                = 1;
   localparam int AESL_BIT_PCM_DATA_ERR             = 0;

   // ***********************************************************
   // carriers
   // ***********************************************************
   // one byte per group, indexed by the AESL_GRP_ constants
   typedef struct packed {
      logic [AESL_GROUPS-1:0][7:0] grp;
   } aesl_bank_s;

   // internal register port request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } aesl_req_s;

endpackage

// file: aesl_event_status.sv
// aesl_event_status: raw condition sampling and sticky event latches
// assumes: raw indicators and clears are synchronous to clk; the control-interface
// engine presents register accesses on the internal request port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - supply bit 7: analog supply undervoltage
// - supply bit 6: core supply undervoltage
// - supply bit 5: power-up complete reported
// - supply bit 4: power-down complete reported
// - supply bit 3: speaker supply undervoltage
// - supply bit 2: battery undervoltage
// - supply bit 1: headroom tracker active
// - supply bit 0: headroom tracking ended
// - brownout bit 3: entered level zero
// - brownout bit 2: level changing
// - brownout bit 1: brownout engine active
// - brownout bit 0: brownout engine no longer active
// - sticky bit sets on raw rise, own clear
// - sticky bits ignore every enable mask
// - thermal sticky layout bits 7 to 0
// - clock/data sticky layout, bit 3 unused
// - supply sticky mirrors supply raw bits
// - thermal raw register layout
// - clock/data raw matches sticky layout
module aesl_event_status
   import aesl_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // raw condition indicators, one byte per group
   input  wire aesl_bank_s raw_in,
   // per-bit clear pulses, one byte per group
   input  wire aesl_bank_s clear_in,
   // internal register port
   input  wire aesl_req_s  req,
   output logic [7:0]      rdata,
   output logic            rvalid,
   // latched views for the rest of the device
   output aesl_bank_s      raw_out,
   output aesl_bank_s      sticky_out
);

   // ***********************************************************
   // elaboration check
   // ***********************************************************
   if (ADDR_W != 16) begin : g_bad_addr_w
      $error("aesl_event_status: ADDR_W must be 16");
   end

   // ***********************************************************
   // package consistency: every named field sits on a kept bit
   // ***********************************************************
   // supply group
   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_ANALOG_SUPPLY_UNDERVOLT]) begin : g_chk_s7
      $error("aesl_event_status: analog supply field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_CORE_SUPPLY_UNDERVOLT]) begin : g_chk_s6
      $error("aesl_event_status: core supply field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_POWERUP_COMPLETE]) begin : g_chk_s5
      $error("aesl_event_status: power-up field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_POWERDOWN_COMPLETE]) begin : g_chk_s4
      $error("aesl_event_status: power-down field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_SPEAKER_SUPPLY_UNDERVOLT]) begin : g_chk_s3
      $error("aesl_event_status: speaker supply field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_BATTERY_UNDERVOLT]) begin : g_chk_s2
      $error("aesl_event_status: battery field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_HEADROOM_TRACK_BEGIN]) begin : g_chk_s1
      $error("aesl_event_status: headroom begin field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_SUPPLY][AESL_BIT_HEADROOM_TRACK_END]) begin : g_chk_s0
      $error("aesl_event_status: headroom end field masked off");
   end

   // brownout group
   if (!AESL_VALID_MASK[AESL_GRP_BROWNOUT][AESL_BIT_BROWNOUT_LEVEL_ZERO]) begin : g_chk_b3
      $error("aesl_event_status: brownout level zero field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_BROWNOUT][AESL_BIT_BROWNOUT_LEVEL_CHANGE]) begin : g_chk_b2
      $error("aesl_event_status: brownout level change field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_BROWNOUT][AESL_BIT_BROWNOUT_BEGIN]) begin : g_chk_b1
      $error("aesl_event_status: brownout begin field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_BROWNOUT][AESL_BIT_BROWNOUT_END]) begin : g_chk_b0
      $error("aesl_event_status: brownout end field masked off");
   end

   if (AESL_VALID_MASK[AESL_GRP_BROWNOUT][7:4] != 4'h0) begin : g_chk_bu
      $error("aesl_event_status: brownout upper bits must stay unused");
   end

   // thermal group
   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_OVERTEMP_SHUTDOWN_BEGIN]) begin : g_chk_t7
      $error("aesl_event_status: shutdown begin field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_OVERTEMP_SHUTDOWN_END]) begin : g_chk_t6
      $error("aesl_event_status: shutdown end field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_TEMP_WARNING_ONE_BEGIN]) begin : g_chk_t5
      $error("aesl_event_status: warning one begin field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_TEMP_WARNING_ONE_END]) begin : g_chk_t4
      $error("aesl_event_status: warning one end field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_THERMAL_FOLDBACK_BEGIN]) begin : g_chk_t3
      $error("aesl_event_status: foldback begin field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_THERMAL_FOLDBACK_END]) begin : g_chk_t2
      $error("aesl_event_status: foldback end field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_FUSE_LOAD_FAILURE]) begin : g_chk_t1
      $error("aesl_event_status: memory load field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_THERMAL][AESL_BIT_SPEAKER_OVERCURRENT]) begin : g_chk_t0
      $error("aesl_event_status: overcurrent field masked off");
   end

   // clock and data group
   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_TEMP_WARNING_TWO_BEGIN]) begin : g_chk_c7
      $error("aesl_event_status: warning two begin field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_TEMP_WARNING_TWO_END]) begin : g_chk_c6
      $error("aesl_event_status: warning two end field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_INTERNAL_SPEAKER_MON_ERR]) begin : g_chk_c5
      $error("aesl_event_status: speaker monitor field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_INTERNAL_CLOCK_ERR]) begin : g_chk_c4
      $error("aesl_event_status: internal clock field masked off");
   end

   if (AESL_VALID_MASK[AESL_GRP_CLOCK][3]) begin : g_chk_c3
      $error("aesl_event_status: clock group bit 3 must stay unused");
   end

   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_CLOCK_RECOVERY]) begin : g_chk_c2
      $error("aesl_event_status: clock recovery field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_CLOCK_ERR]) begin : g_chk_c1
      $error("aesl_event_status: clock error field masked off");
   end

   if (!AESL_VALID_MASK[AESL_GRP_CLOCK][AESL_BIT_PCM_DATA_ERR]) begin : g_chk_c0
      $error("aesl_event_status: data error field masked off");
   end

   // ***********************************************************
   // state
   // ***********************************************************
   aesl_bank_s raw_reg;
   aesl_bank_s raw_next;
   aesl_bank_s sticky_reg;
   aesl_bank_s sticky_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;
   logic       rvalid_next;

   // ***********************************************************
   // raw sampling and sticky latches, per group
   // ***********************************************************
   for (genvar g = 0; g < AESL_GROUPS; g++) begin : g_grp
      always_comb begin
         // raw bits follow their indicator levels
         raw_next.grp[g] = raw_in.grp[g] & AESL_VALID_MASK[g];
         // rise sets, clear drops until the next rise, rise beats clear, unused bits masked by AESL_VALID_MASK
         sticky_next.grp[g] = ((sticky_reg.grp[g] & ~clear_in.grp[g])
                               | (raw_next.grp[g] & ~raw_reg.grp[g]))
                              & AESL_VALID_MASK[g];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         raw_reg    <= '{grp: {AESL_GROUPS{AESL_RESET_VALUE}}};
         sticky_reg <= '{grp: {AESL_GROUPS{AESL_RESET_VALUE}}};
      end else begin
         raw_reg    <= raw_next;
         sticky_reg <= sticky_next;
      end
   end

   // ***********************************************************
   // register read port
   // ***********************************************************
   always_comb begin
      rdata_next  = rdata_reg;
      rvalid_next = req.rd;
      // writes to these addresses have no effect
      if (req.rd) begin
         case (req.addr)
            AESL_RAW_THERMAL_ADDR:   rdata_next = raw_reg.grp[AESL_GRP_THERMAL];
            AESL_RAW_CLOCK_ADDR:     rdata_next = raw_reg.grp[AESL_GRP_CLOCK];
            AESL_RAW_SUPPLY_ADDR:    rdata_next = raw_reg.grp[AESL_GRP_SUPPLY];
            AESL_RAW_BROWNOUT_ADDR:  rdata_next = raw_reg.grp[AESL_GRP_BROWNOUT];
            AESL_STKY_THERMAL_ADDR:  rdata_next = sticky_reg.grp[AESL_GRP_THERMAL];
            AESL_STKY_CLOCK_ADDR:    rdata_next = sticky_reg.grp[AESL_GRP_CLOCK];
            AESL_STKY_SUPPLY_ADDR:   rdata_next = sticky_reg.grp[AESL_GRP_SUPPLY];
            AESL_STKY_BROWNOUT_ADDR: rdata_next = sticky_reg.grp[AESL_GRP_BROWNOUT];
            default:                 rdata_next = AESL_UNMAPPED_VALUE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg  <= AESL_RESET_VALUE;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign rdata      = rdata_reg;
   assign rvalid     = rvalid_reg;
   assign raw_out    = raw_reg;
   assign sticky_out = sticky_reg;

endmodule

`default_nettype wire

// file: aesl_event_status_chk.sv
// checker for the event status latches
// assumes: bound to aesl_event_status, one clock domain
`timescale 1ns/1ps
`default_nettype none
module aesl_event_status_chk
   import aesl_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // watched ports
   input wire aesl_bank_s raw_in,
   input wire aesl_bank_s clear_in,
   input wire aesl_req_s  req,
   input wire logic [7:0] rdata,
   input wire logic       rvalid,
   input wire aesl_bank_s raw_out,
   input wire aesl_bank_s sticky_out
);
   // ***
   // helpers
   // ***
   localparam logic [31:0] M = AESL_VALID_MASK;
   logic [31:0] rise;
   assign rise = raw_in & M & ~raw_out;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_rd(logic [15:0] a); req.rd && req.addr == a; endsequence
   // ***
   // assertions
   // ***
   property p_rv; $past(rst_b) |-> rvalid == $past(req.rd); endproperty
   a_rv: assert property (p_rv) else $error("read answer timing");
   property p_raw; $past(rst_b) |-> raw_out == ($past(raw_in) & M); endproperty
   a_raw: assert property (p_raw) else $error("raw sample");
   property p_unused; ((raw_out | sticky_out) & ~M) == 0; endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");
   property p_set; rise != 0 |=> (sticky_out & $past(rise)) == $past(rise); endproperty
   a_set: assert property (p_set) else $error("rise not latched");
   property p_hold; $past(rst_b) |-> ($past(sticky_out & ~clear_in) & ~sticky_out) == 0; endproperty
   a_hold: assert property (p_hold) else $error("sticky lost");
   property p_clr; $past(rst_b) |-> (sticky_out & $past(clear_in & ~rise)) == 0; endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");
   property p_only; $past(rst_b) |-> (sticky_out & ~$past(sticky_out | rise)) == 0; endproperty
   a_only: assert property (p_only) else $error("spurious set");
   property p_rd_sup; s_rd(AESL_RAW_SUPPLY_ADDR) |=> rdata == $past(raw_out.grp[2]); endproperty
   a_rd_sup: assert property (p_rd_sup) else $error("raw supply read");
   property p_rd_bo; s_rd(AESL_RAW_BROWNOUT_ADDR) |=> rdata == $past(raw_out.grp[3]); endproperty
   a_rd_bo: assert property (p_rd_bo) else $error("raw brownout read");
   property p_st_thm; s_rd(AESL_STKY_THERMAL_ADDR) |=> rdata == $past(sticky_out.grp[0]); endproperty
   a_st_thm: assert property (p_st_thm) else $error("sticky thermal read");
endmodule
bind aesl_event_status aesl_event_status_chk u_chk (.clk(clk), .rst_b(rst_b), .raw_in(raw_in),
   .clear_in(clear_in), .req(req), .rdata(rdata), .rvalid(rvalid), .raw_out(raw_out),
   .sticky_out(sticky_out));
`default_nettype wire

// file: aesl_host.sv
// host model issuing register port requests
// assumes: called just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module aesl_host
   import aesl_pkg::*;
(
   // clock
   input  wire logic      clk,
   // request toward the device
   output var aesl_req_s  req
);
   initial req = '0;
   // one-cycle request, then one idle cycle
   task automatic acc(input logic rd, wr, input logic [15:0] a, input logic [7:0] d);
      req = '{rd: rd, wr: wr, addr: a, wdata: d};
      @(posedge clk);
      #1 req = '0;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// file: aesl_tb.sv
// self-checking bench for the event status latches
// assumes: aesl_host drives the register port, bench drives raw and clear
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb
   import aesl_pkg::*;
   ;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   aesl_bank_s  raw_in = '0;
   aesl_bank_s  clear_in = '0;
   aesl_req_s   req;
   logic [7:0]  rdata, ev;
   logic        rvalid;
   aesl_bank_s  raw_out, sticky_out;
   logic [31:0] m_raw, m_stk, w;
   logic [7:0]  q[$];
   int          error_cnt = 0;
   int          n_compared = 0;
   int          seed = 32'hE2B97B9C;
   aesl_host u_host (.clk(clk), .req(req));
   aesl_event_status u_dut (.clk(clk), .rst_b(rst_b), .raw_in(raw_in), .clear_in(clear_in),
      .req(req), .rdata(rdata), .rvalid(rvalid), .raw_out(raw_out), .sticky_out(sticky_out));
   initial forever #50 clk = ~clk;
   // reference latches
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         m_raw <= '0;
         m_stk <= '0;
      end else begin
         m_stk <= (m_stk & ~clear_in) | (raw_in & AESL_VALID_MASK & ~m_raw);
         m_raw <= raw_in & AESL_VALID_MASK;
      end
   end
   function automatic logic [7:0] expv(input logic [15:0] a);
      if (a >= AESL_RAW_THERMAL_ADDR && a <= AESL_RAW_BROWNOUT_ADDR)
         return m_raw[8*(a-AESL_RAW_THERMAL_ADDR) +: 8];
      if (a >= AESL_STKY_THERMAL_ADDR && a <= AESL_STKY_BROWNOUT_ADDR)
         return m_stk[8*(a-AESL_STKY_THERMAL_ADDR) +: 8];
      return AESL_UNMAPPED_VALUE;
   endfunction
   task automatic step(input logic [31:0] r, c, input logic rd, wr, input logic [15:0] a,
                       input logic [7:0] d);
      raw_in = r;
      clear_in = c;
      if (rd) q.push_back(expv(a));
      u_host.acc(rd, wr, a, d);
   endtask
   task automatic end_sim;
      if (q.size() != 0) error_cnt++;
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // output monitor
   always @(negedge clk) begin
      `CHK(raw_out, m_raw)
      `CHK(sticky_out, m_stk)
      if (rvalid === 1'b1) begin
         ev = q.pop_front();
         `CHK(rdata, ev)
      end
   end
   initial begin
      #200000;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 11; i++) step('0, '0, 1'b1, 1'b1, 16'h2000 + 16'(i), 8'hFF);
      for (int i = 0; i < 32; i++) begin
         step(32'h1 << i, '0, 1'b1, 1'b0, AESL_RAW_THERMAL_ADDR + 16'(i / 8), 8'h00);
         step(32'h1 << i, '1, 1'b1, 1'b1, AESL_STKY_THERMAL_ADDR + 16'(i / 8), 8'hFF);
      end
      for (int n = 0; n < 300; n++) begin
         w = $random(seed);
         step($random(seed), $random(seed) & $random(seed), w[0] | w[1], w[2],
              16'h2000 + 16'({w[31:8]} % 11), w[15:8]);
      end
      repeat (3) @(posedge clk);
      end_sim;
   end
endmodule
`default_nettype wire
